// *** hdl/tpc_pkg.sv ***
// Constants shared by the chained tick and time-of-day clock
package tpc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TB_PERIOD_NS = 400;
  localparam int TB_DIV = (TB_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TB_DIV_W = 6;
  localparam logic [TB_DIV_W-1:0] TB_LAST = TB_DIV_W'(TB_DIV - 1);
  localparam logic [TB_DIV_W-1:0] TB_HALF = TB_DIV_W'(TB_DIV / 2);

  localparam int ADDR_W = 9;
  localparam logic [ADDR_W-1:0] OFS_TICK_HIGH = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_TICK_LOW = 9'h008;
  localparam logic [ADDR_W-1:0] OFS_TICK_STATUS = 9'h010;
  localparam logic [ADDR_W-1:0] OFS_TOD_SEC = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_TOD_NSEC = 9'h108;
  localparam logic [ADDR_W-1:0] OFS_TOD_STATUS = 9'h110;

  localparam logic [31:0] NS_STEP = 32'h0000_0190;
  localparam logic [31:0] NS_PER_SEC = 32'h3b9a_ca00;
  localparam logic [63:0] TICK_RESET = 64'h0;
  localparam logic [31:0] TOD_RESET = 32'h0;
  localparam logic [31:0] ZERO_WORD = 32'h0;

  localparam int TOD_BITS = 64;
  localparam int BIT_CNT_W = 7;

  // Status word bit positions
  localparam int ST_MASTER = 0;
  localparam int ST_CLR_ACTIVE = 1;
  localparam int ST_CABLE_LVL = 2;
  localparam int ST_RX_VALID = 3;
  localparam int ST_BCAST_BUSY = 4;
  localparam int ST_MSI = 5;
  localparam int ST_IRQ = 6;
endpackage

// *** hdl/tpc_sync.sv ***
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module tpc_sync
  import tpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  logic meta;
  logic s2;
  logic s3;
  logic next_meta;
  logic next_s2;
  logic next_s3;

  always_comb
  begin
    next_meta = meta;
    next_s2 = s2;
    next_s3 = s3;
    if (ce)
    begin
      next_meta = d;
      next_s2 = meta;
      next_s3 = s2;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      meta <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      s2 <= next_s2;
      s3 <= next_s3;
    end
  end

  // Edges look only at the second and third flops
  assign q = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule

// *** hdl/tpc_ser.sv ***
// Serialiser that sends a 64-bit time-of-day frame, MSB first
`timescale 1ns/1ps
module tpc_ser
  import tpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic [63:0] load_val,
  input wire logic step,
  output logic bit_out,
  output logic frame
);
  logic [63:0] shreg;
  logic [BIT_CNT_W-1:0] left;
  logic [63:0] next_shreg;
  logic [BIT_CNT_W-1:0] next_left;

  always_comb
  begin
    next_shreg = shreg;
    next_left = left;
    if (ce)
    begin
      // Armed one extra step so the frame opens mid-period and every bit spans a full period
      if (start && left == '0)
      begin
        next_shreg = load_val;
        next_left = BIT_CNT_W'(TOD_BITS + 1);
      end
      else if (step && left != '0)
      begin
        if (left != BIT_CNT_W'(TOD_BITS + 1))
          next_shreg = {shreg[62:0], 1'b0};
        next_left = left - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      shreg <= 64'h0;
      left <= '0;
    end
    else
    begin
      shreg <= next_shreg;
      left <= next_left;
    end
  end

  assign bit_out = shreg[63];
  assign frame = (left != '0) && (left != BIT_CNT_W'(TOD_BITS + 1));
endmodule

// *** hdl/tpc_clock.sv ***
// Chained tick counter and seconds/nanoseconds time-of-day counter
`timescale 1ns/1ps
module tpc_clock
  import tpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic is_master,
  input wire logic tick_clr_cmd,
  input wire logic tb_clk_in,
  input wire logic tick_clr_in,
  input wire logic tod_frame_in,
  input wire logic tod_bit_in,
  output logic tb_clk_out,
  output logic tick_clr_out,
  output logic tod_frame_out,
  output logic tod_bit_out,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic msi_enable,
  input wire logic irq_event,
  input wire logic irq_ack,
  output logic msi_req,
  output logic inta_n
);
  function automatic logic [31:0] ns_add(input logic [31:0] ns);
    logic [31:0] sum;
    sum = ns + NS_STEP;
    if (sum >= NS_PER_SEC)
      ns_add = sum - NS_PER_SEC;
    else
      ns_add = sum;
  endfunction

  // Cable inputs, synchronised
  logic cab_clk;
  logic cab_clk_rise;
  logic cab_clr;
  logic cab_frm;
  logic cab_frm_fall;
  logic cab_bit;
  logic cab_bit_rise;
  logic cab_bit_fall;
  logic cab_frm_rise;
  logic cab_clr_rise;
  logic cab_clr_fall;
  logic cab_clk_fall;

  tpc_sync u_sync_clk (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .d(tb_clk_in),
    .q(cab_clk), .rise(cab_clk_rise), .fall(cab_clk_fall)
  );
  tpc_sync u_sync_clr (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .d(tick_clr_in),
    .q(cab_clr), .rise(cab_clr_rise), .fall(cab_clr_fall)
  );
  tpc_sync u_sync_frm (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .d(tod_frame_in),
    .q(cab_frm), .rise(cab_frm_rise), .fall(cab_frm_fall)
  );
  tpc_sync u_sync_bit (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .d(tod_bit_in),
    .q(cab_bit), .rise(cab_bit_rise), .fall(cab_bit_fall)
  );

  // Timebase
  logic [TB_DIV_W-1:0] div;
  logic [TB_DIV_W-1:0] next_div;
  logic tick;
  logic half;

  always_comb
  begin
    next_div = div;
    if (ce)
      next_div = (div == TB_LAST) ? '0 : div + 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      div <= '0;
    else
      div <= next_div;
  end

  // A slave never uses its own divider, so the whole chain shares one oscillator
  assign tick = is_master ? (div == TB_LAST) : cab_clk_rise;
  assign half = is_master ? (div == TB_HALF) : cab_clk_fall;

  // Counters
  logic [63:0] tick_cnt;
  logic [31:0] tod_sec;
  logic [31:0] tod_ns;
  logic clr_pend;
  logic [63:0] next_tick_cnt;
  logic [31:0] next_tod_sec;
  logic [31:0] next_tod_ns;
  logic next_clr_pend;
  logic clr_active;
  logic sec_roll;
  logic wr_sec;
  logic wr_ns;

  assign wr_sec = reg_wr && reg_addr == OFS_TOD_SEC;
  assign wr_ns = reg_wr && reg_addr == OFS_TOD_NSEC;
  assign clr_active = is_master ? clr_pend : cab_clr;
  assign sec_roll = tick && (tod_ns + NS_STEP >= NS_PER_SEC);

  always_comb
  begin
    next_tick_cnt = tick_cnt;
    next_tod_sec = tod_sec;
    next_tod_ns = tod_ns;
    next_clr_pend = clr_pend;
    if (ce)
    begin
      // Clear is held from the command until the next tick, so slaves see it for between one cycle and one full period
      if (is_master && tick_clr_cmd)
        next_clr_pend = 1'b1;
      else if (tick)
        next_clr_pend = 1'b0;
      if (!is_master)
        next_clr_pend = 1'b0;
      if (clr_active)
        next_tick_cnt = TICK_RESET;
      else if (tick)
        next_tick_cnt = tick_cnt + 64'h1;
      if (tick)
      begin
        next_tod_ns = ns_add(tod_ns);
        if (sec_roll)
          next_tod_sec = tod_sec + 32'h1;
      end
      // Host load wins over the tick in the same cycle
      if (wr_sec)
        next_tod_sec = reg_wdata;
      if (wr_ns)
        next_tod_ns = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      tick_cnt <= TICK_RESET;
      tod_sec <= TOD_RESET;
      tod_ns <= TOD_RESET;
      clr_pend <= 1'b0;
    end
    else
    begin
      tick_cnt <= next_tick_cnt;
      tod_sec <= next_tod_sec;
      tod_ns <= next_tod_ns;
      clr_pend <= next_clr_pend;
    end
  end

  // Broadcast of the new time at each whole second
  logic ser_bit;
  logic ser_frame;
  logic bcast_start;

  assign bcast_start = is_master && sec_roll;

  tpc_ser u_ser (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .start(bcast_start),
    .load_val({tod_sec + 32'h1, ns_add(tod_ns)}), .step(half),
    .bit_out(ser_bit), .frame(ser_frame)
  );

  // Broadcast receiver, samples mid-bit on the timebase rising edge
  logic [63:0] rx_sh;
  logic rx_valid;
  logic [63:0] next_rx_sh;
  logic next_rx_valid;

  always_comb
  begin
    next_rx_sh = rx_sh;
    next_rx_valid = rx_valid;
    if (ce && !is_master)
    begin
      if (cab_frm && tick)
        next_rx_sh = {rx_sh[62:0], cab_bit};
      if (cab_frm_fall)
        next_rx_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rx_sh <= 64'h0;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_sh <= next_rx_sh;
      rx_valid <= next_rx_valid;
    end
  end

  // Cable outputs; a slave passes the chain on downstream
  logic next_tb_clk_out;
  logic next_tick_clr_out;
  logic next_tod_frame_out;
  logic next_tod_bit_out;

  always_comb
  begin
    next_tb_clk_out = tb_clk_out;
    next_tick_clr_out = tick_clr_out;
    next_tod_frame_out = tod_frame_out;
    next_tod_bit_out = tod_bit_out;
    if (ce)
    begin
      if (is_master)
      begin
        next_tb_clk_out = (div < TB_HALF);
        next_tick_clr_out = clr_pend;
        next_tod_frame_out = ser_frame;
        next_tod_bit_out = ser_bit;
      end
      else
      begin
        next_tb_clk_out = cab_clk;
        next_tick_clr_out = cab_clr;
        next_tod_frame_out = cab_frm;
        next_tod_bit_out = cab_bit;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      tb_clk_out <= 1'b0;
      tick_clr_out <= 1'b0;
      tod_frame_out <= 1'b0;
      tod_bit_out <= 1'b0;
    end
    else
    begin
      tb_clk_out <= next_tb_clk_out;
      tick_clr_out <= next_tick_clr_out;
      tod_frame_out <= next_tod_frame_out;
      tod_bit_out <= next_tod_bit_out;
    end
  end

  // Interrupt signalling
  logic irq_pend;
  logic next_irq_pend;
  logic next_msi_req;
  logic next_inta_n;

  always_comb
  begin
    next_irq_pend = irq_pend;
    next_msi_req = 1'b0;
    next_inta_n = inta_n;
    if (ce)
    begin
      // A new event beats an acknowledge in the same cycle
      if (irq_event)
        next_irq_pend = 1'b1;
      else if (irq_ack)
        next_irq_pend = 1'b0;
      next_msi_req = msi_enable && irq_event;
      next_inta_n = ~(!msi_enable && next_irq_pend);
    end
    else
      next_msi_req = msi_req;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      irq_pend <= 1'b0;
      msi_req <= 1'b0;
      inta_n <= 1'b1;
    end
    else
    begin
      irq_pend <= next_irq_pend;
      msi_req <= next_msi_req;
      inta_n <= next_inta_n;
    end
  end

  // Register window, one-cycle read latency
  logic [31:0] status;
  logic [31:0] low_snap;
  logic [31:0] next_low_snap;
  logic [31:0] next_rdata;
  logic next_rvalid;

  always_comb
  begin
    status = ZERO_WORD;
    status[ST_MASTER] = is_master;
    status[ST_CLR_ACTIVE] = clr_active;
    status[ST_CABLE_LVL] = cab_clk;
    status[ST_RX_VALID] = rx_valid;
    status[ST_BCAST_BUSY] = ser_frame;
    status[ST_MSI] = msi_enable;
    status[ST_IRQ] = irq_pend;
  end

  always_comb
  begin
    next_low_snap = low_snap;
    next_rdata = reg_rdata;
    next_rvalid = reg_rvalid;
    if (ce)
    begin
      next_rvalid = reg_rd;
      next_rdata = ZERO_WORD;
      if (reg_rd)
      begin
        case (reg_addr)
          OFS_TICK_HIGH:
          begin
            // Low half frozen so a high-then-low read pair is coherent
            next_rdata = tick_cnt[63:32];
            next_low_snap = tick_cnt[31:0];
          end
          OFS_TICK_LOW: next_rdata = low_snap;
          OFS_TICK_STATUS: next_rdata = status;
          OFS_TOD_SEC: next_rdata = tod_sec;
          OFS_TOD_NSEC: next_rdata = tod_ns;
          OFS_TOD_STATUS: next_rdata = status;
          default: next_rdata = ZERO_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      low_snap <= ZERO_WORD;
      reg_rdata <= ZERO_WORD;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      low_snap <= next_low_snap;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end
endmodule

// *** testbench/tpc_clock_sva.sv ***
// Port assertions for the chained tick and time-of-day clock
`timescale 1ns/1ps
module tpc_clock_sva
  import tpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic is_master,
  input wire logic tb_clk_in,
  input wire logic tick_clr_in,
  input wire logic tb_clk_out,
  input wire logic tick_clr_out,
  input wire logic tod_frame_out,
  input wire logic reg_rd,
  input wire logic reg_rvalid,
  input wire logic msi_enable,
  input wire logic irq_event,
  input wire logic irq_ack,
  input wire logic msi_req,
  input wire logic inta_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [11:0] fcnt;
  // Counts cycles of a running frame
  always_ff @(posedge ref_clk)
    fcnt <= (!nrst || !tod_frame_out) ? 12'h000 : fcnt + 12'h001;
  sequence s_pulse;
    msi_req ##1 !msi_req;
  endsequence
  sequence s_high;
    ##19 tb_clk_out ##1 !tb_clk_out;
  endsequence
  a_tb_period: assert property (
    is_master && ce && $rose(tb_clk_out) |-> ##40 $rose(tb_clk_out))
    else $error("timebase period wrong");
  a_tb_high: assert property (
    is_master && $rose(tb_clk_out) |-> s_high)
    else $error("timebase high time wrong");
  a_fwd_clk: assert property (
    !is_master && $past(nrst, 3) |-> tb_clk_out == $past(tb_clk_in, 3))
    else $error("timebase not forwarded");
  a_fwd_clr: assert property (
    !is_master && $past(nrst, 3) |-> tick_clr_out == $past(tick_clr_in, 3))
    else $error("clear not forwarded");
  a_frame_len: assert property (
    is_master && $fell(tod_frame_out) |-> fcnt == 12'ha00)
    else $error("broadcast frame length wrong");
  a_msi_pulse: assert property (
    irq_event && msi_enable |=> s_pulse)
    else $error("message interrupt pulse wrong");
  a_inta_set: assert property (
    irq_event && !msi_enable |=> !inta_n)
    else $error("legacy line not asserted");
  a_inta_hold: assert property (
    !inta_n && !irq_ack |=> !inta_n)
    else $error("legacy line dropped early");
  a_rd_answer: assert property (
    ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");
endmodule
bind tpc_clock tpc_clock_sva u_sva (.*);

// *** testbench/tpc_upstream.sv ***
// Upstream chain board driving the cable inputs
`timescale 1ns/1ps
module tpc_upstream
  import tpc_pkg::*;
(
  input wire logic run,
  input wire logic clr,
  output logic tb_clk_in,
  output logic tick_clr_in,
  output logic tod_frame_in,
  output logic tod_bit_in
);
  assign tick_clr_in = clr;
  initial
  begin
    tb_clk_in = 1'b0;
    tod_frame_in = 1'b0;
    tod_bit_in = 1'b0;
    // Offset keeps cable edges away from the sampling clock's edges
    #1;
    forever
    begin
      #62.5;
      if (run)
        tb_clk_in = ~tb_clk_in;
    end
  end
  // Bits change on falling edges so each rising edge sees a settled bit
  task automatic send(input logic [63:0] v);
    @(negedge tb_clk_in);
    tod_frame_in = 1'b1;
    for (int i = 63; i >= 0; i--)
    begin
      tod_bit_in = v[i];
      @(negedge tb_clk_in);
    end
    tod_frame_in = 1'b0;
    // Released line must not keep the last bit
    tod_bit_in = ~tod_bit_in;
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the chained tick and time-of-day clock
`timescale 1ns/1ps
module tb_top
  import tpc_pkg::*;
();
  localparam int LINK_NS = 125;
  localparam logic [ADDR_W-1:0] RO [4] = '{OFS_TICK_HIGH, OFS_TICK_LOW, OFS_TICK_STATUS,
    OFS_TOD_STATUS};
  logic ref_clk, nrst, ce, is_master, tick_clr_cmd, reg_rd, reg_wr;
  logic msi_enable, irq_event, irq_ack, run, clr;
  logic tb_clk_in, tick_clr_in, tod_frame_in, tod_bit_in;
  logic tb_clk_out, tick_clr_out, tod_frame_out, tod_bit_out;
  logic reg_rvalid, msi_req, inta_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d, n0, n1;
  logic [63:0] t0, t1, got;
  int errors = 0;
  int total_checks = 0;
  tpc_clock u_dut (.*);
  tpc_upstream u_up (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    v = reg_rdata;
    chk("rvalid", 1'b1, reg_rvalid);
    cyc(1);
  endtask
  task automatic rtick(output logic [63:0] t);
    logic [31:0] h, l;
    rd(OFS_TICK_HIGH, h);
    rd(OFS_TICK_LOW, l);
    t = {h, l};
  endtask
  task automatic do_reset(input logic m);
    is_master = m;
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #500_000;
    errors++;
    conclude();
  end
  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    {is_master, tick_clr_cmd, reg_rd, reg_wr, msi_enable, irq_event, irq_ack} = '0;
    {run, clr, reg_addr, reg_wdata} = '0;
    do_reset(1'b1);
    rtick(t0);
    chk("tick_reset", TICK_RESET, t0);
    rd(OFS_TOD_SEC, d);
    chk("sec_reset", TOD_RESET, d);
    rd(OFS_TOD_NSEC, d);
    chk("ns_reset", TOD_RESET, d);
    rd(OFS_TICK_STATUS, d);
    chk("status", 32'h1, d);
    rd(9'h004, d);
    chk("unmapped", ZERO_WORD, d);
    $display("test reset done");
    rtick(t0);
    rd(OFS_TOD_NSEC, n0);
    cyc(10 * TB_DIV - 6);
    rtick(t1);
    rd(OFS_TOD_NSEC, n1);
    chk("tick_rate", 64'ha, t1 - t0);
    chk("ns_rate", 10 * NS_STEP, n1 - n0);
    $display("test rate done");
    foreach (RO[i]) wr(RO[i], 32'hffff_ffff);
    rtick(t0);
    chk("tick_hi_kept", ZERO_WORD, t0[63:32]);
    rd(OFS_TICK_STATUS, d);
    chk("status_kept", 32'h1, d);
    rd(OFS_TOD_STATUS, d);
    chk("tod_status_kept", 32'h1, d);
    $display("test read-only done");
    @(posedge tb_clk_out);
    #1;
    tick_clr_cmd = 1'b1;
    cyc(1);
    tick_clr_cmd = 1'b0;
    cyc(1);
    chk("clr_out", 1'b1, tick_clr_out);
    rtick(t0);
    chk("tick_cleared", TICK_RESET, t0);
    $display("test clear done");
    wr(OFS_TOD_SEC, 32'h5);
    wr(OFS_TOD_NSEC, NS_PER_SEC - 2 * NS_STEP);
    for (int i = 0; i < 200 && tod_frame_out !== 1'b1; i++) cyc(1);
    chk("frame_start", 1'b1, tod_frame_out);
    for (int i = 63; i >= 0; i--)
    begin
      @(posedge tb_clk_out);
      #1;
      got[i] = tod_bit_out;
    end
    chk("bcast_value", {32'h6, ZERO_WORD}, got);
    rd(OFS_TOD_SEC, d);
    chk("sec_roll", 32'h6, d);
    rd(OFS_TOD_NSEC, d);
    chk("ns_step", ZERO_WORD, d % NS_STEP);
    cyc(100);
    $display("test broadcast done");
    msi_enable = 1'b1;
    irq_event = 1'b1;
    cyc(1);
    irq_event = 1'b0;
    chk("msi_req", 1'b1, msi_req);
    chk("inta_idle", 1'b1, inta_n);
    cyc(1);
    msi_enable = 1'b0;
    irq_event = 1'b1;
    cyc(1);
    irq_event = 1'b0;
    cyc(5);
    chk("inta_low", 1'b0, inta_n);
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    cyc(1);
    chk("inta_ack", 1'b1, inta_n);
    $display("test interrupt done");
    run = 1'b1;
    do_reset(1'b0);
    cyc(20);
    rtick(t0);
    rd(OFS_TOD_NSEC, n0);
    cyc(20 * LINK_NS / CLK_PERIOD_NS - 6);
    rtick(t1);
    rd(OFS_TOD_NSEC, n1);
    chk("slave_rate", 64'h14, t1 - t0);
    chk("slave_ns", 20 * NS_STEP, n1 - n0);
    clr = 1'b1;
    cyc(10);
    rtick(t0);
    chk("slave_clear", TICK_RESET, t0);
    clr = 1'b0;
    cyc(30);
    tick_clr_cmd = 1'b1;
    cyc(1);
    tick_clr_cmd = 1'b0;
    rtick(t0);
    chk("slave_cmd_ignored", 1'b1, t0 != TICK_RESET);
    rd(OFS_TOD_STATUS, d);
    chk("rx_before", 1'b0, d[ST_RX_VALID]);
    u_up.send({32'h7, NS_STEP});
    cyc(10);
    rd(OFS_TOD_STATUS, d);
    chk("rx_valid", 1'b1, d[ST_RX_VALID]);
    $display("test slave done");
    conclude();
  end
endmodule
